/* hw/osd_pkg.sv */
package osd_pkg;
   localparam logic [11:0] OFS_OSC_CTRL  = 12'h000;
   localparam logic [11:0] OFS_CLK_DIV   = 12'h004;
   localparam logic [11:0] OFS_PLL_FBD   = 12'h008;
   localparam logic [11:0] OFS_UNLOCK    = 12'h00C;
   localparam logic [31:0] UNLOCK_KEY1   = 32'h0000_0057;
   localparam logic [31:0] UNLOCK_KEY2   = 32'h0000_00AA;
   localparam logic [2:0]  SRC_RESERVED  = 3'h4;
   localparam logic [2:0]  SRC_FRC       = 3'h0;
   localparam logic [2:0]  SRC_FRC_PLL   = 3'h1;
   localparam logic [2:0]  SRC_PRI_PLL   = 3'h3;
   localparam logic [2:0]  DOZE_RST      = 3'h3;
   localparam logic [2:0]  DOZE_NONE     = 3'h0;
   localparam logic [2:0]  FAST_RC_POSTSCALER_RST    = 3'h0;
   localparam logic [1:0]  POST_RST      = 2'h1;
   localparam logic [1:0]  POST_RSVD     = 2'h2;
   localparam logic [4:0]  PRE_RST       = 5'h00;
   localparam logic [8:0]  FBD_RST       = 9'h030;
   // OSC control bit positions
   localparam int B_CURRENT_SOURCE_SEL = 12;
   localparam int B_NEXT_SOURCE_SEL = 8;
   localparam int B_CLOCK_CONFIG_LOCK = 7;
   localparam int B_PIN_CONFIG_LOCK = 6;
   localparam int B_LOCK = 5;
   localparam int B_CF = 3;
   localparam int B_SOURCE_SWITCH_REQUEST = 0;
   // Clock divisor bit positions
   localparam int B_ROI = 15;
   localparam int B_DOZE = 12;
   localparam int B_REDUCED_RATIO_ENABLE = 11;
   localparam int B_FAST_RC_POSTSCALER = 8;
   localparam int B_POST = 6;
   localparam int B_PRE = 0;

   typedef enum logic [1:0] {
      OSD_IDLE  = 2'b00,
      OSD_WAIT  = 2'b01,
      OSD_SWAP  = 2'b11
   } osd_sw_t;

   typedef enum logic [1:0] {
      OSD_LK0 = 2'b00,
      OSD_LK1 = 2'b01,
      OSD_LK2 = 2'b11
   } osd_unlock_t;

   typedef struct packed {
      logic [2:0] cur_src;
      logic [2:0] next_src;
      logic       switch_req;
      logic       clk_lock;
      logic       pin_lock;
      logic       fail_flag;
      logic       recover_on_irq;
      logic [2:0] doze;
      logic       reduced_ratio_enable;
      logic [2:0] fast_rc_postscaler;
      logic [1:0] post;
      logic [4:0] pre;
      logic [8:0] fbd;
   } osd_regs_t;

   typedef struct packed {
      logic [2:0] source;
      logic [2:0] frc_div;
      logic [1:0] post;
      logic [4:0] pre;
      logic [8:0] fbd;
      logic [2:0] doze_ratio;
   } osd_clkcfg_t;
endpackage

/* hw/osd_ctrl.sv */
module osd_ctrl (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 por_load,
   input  wire logic [2:0]           cfg_next_source_sel,
   input  wire logic                 cfg_clock_switch_monitor_cfg0,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 irq_any,
   input  wire logic                 src_ready_async,
   input  wire logic                 pll_lock_async,
   input  wire logic                 fail_detect_async,
   output osd_pkg::osd_clkcfg_t      clk_cfg,
   output logic                      io_lock_active,
   output logic                      osc_fail_trap
);
   typedef struct packed {
      osd_pkg::osd_regs_t    r;
      osd_pkg::osd_sw_t      sw;
      osd_pkg::osd_unlock_t  ul;
      logic [2:0]            sy_ready;
      logic [1:0]            sy_lock;
      logic [1:0]            sy_fail;
      logic [31:0]           rdata;
      logic                  trap;
   } osd_state_t;

   osd_state_t s_q, s_d;

   function automatic logic [31:0] field(input logic [31:0] v, input int pos, input int w);
      return (v >> pos) & ((32'h0000_0001 << w) - 32'h0000_0001);
   endfunction

   logic acc, wr, rd, locked_cfg, fail_evt;
   logic [31:0] osc_word, div_word, fbd_word, rd_mux;
   logic hit;

   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   // Read word captured in the setup phase so it stands at the access edge
   assign rd  = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign locked_cfg = s_q.r.clk_lock & cfg_clock_switch_monitor_cfg0;
   assign fail_evt = s_q.sy_fail[1];

   always_comb begin
      osc_word = '0;
      osc_word[osd_pkg::B_CURRENT_SOURCE_SEL +: 3] = s_q.r.cur_src;
      osc_word[osd_pkg::B_NEXT_SOURCE_SEL +: 3] = s_q.r.next_src;
      osc_word[osd_pkg::B_CLOCK_CONFIG_LOCK]   = s_q.r.clk_lock;
      osc_word[osd_pkg::B_PIN_CONFIG_LOCK]    = s_q.r.pin_lock;
      osc_word[osd_pkg::B_LOCK]      = s_q.sy_lock[1];
      osc_word[osd_pkg::B_CF]        = s_q.r.fail_flag;
      osc_word[osd_pkg::B_SOURCE_SWITCH_REQUEST]     = s_q.r.switch_req;
      div_word = '0;
      div_word[osd_pkg::B_ROI]          = s_q.r.recover_on_irq;
      div_word[osd_pkg::B_DOZE +: 3]    = s_q.r.doze;
      div_word[osd_pkg::B_REDUCED_RATIO_ENABLE]        = s_q.r.reduced_ratio_enable;
      div_word[osd_pkg::B_FAST_RC_POSTSCALER +: 3]  = s_q.r.fast_rc_postscaler;
      div_word[osd_pkg::B_POST +: 2]    = s_q.r.post;
      div_word[osd_pkg::B_PRE +: 5]     = s_q.r.pre;
      fbd_word = {23'h0, s_q.r.fbd};
      hit = 1'b1;
      case (paddr)
         osd_pkg::OFS_OSC_CTRL: rd_mux = osc_word;
         osd_pkg::OFS_CLK_DIV:  rd_mux = div_word;
         osd_pkg::OFS_PLL_FBD:  rd_mux = fbd_word;
         osd_pkg::OFS_UNLOCK:   rd_mux = '0;
         default: begin
            rd_mux = '0;
            hit = 1'b0;
         end
      endcase
   end
   assign pslverr = acc & ~hit;

   always_comb begin
      s_d = s_q;
      s_d.trap = 1'b0;
      // Synchronisers: stage one feeds only stage two
      s_d.sy_ready = {s_q.sy_ready[1:0], src_ready_async};
      s_d.sy_lock  = {s_q.sy_lock[0], pll_lock_async};
      s_d.sy_fail  = {s_q.sy_fail[0], fail_detect_async};
      if (rd) begin
         s_d.rdata = rd_mux;
      end
      // Unlock sequence: two key writes arm one control write
      if (wr && paddr == osd_pkg::OFS_UNLOCK) begin
         if (pwdata == osd_pkg::UNLOCK_KEY1) begin
            s_d.ul = osd_pkg::OSD_LK1;
         end else if (pwdata == osd_pkg::UNLOCK_KEY2 && s_q.ul == osd_pkg::OSD_LK1) begin
            s_d.ul = osd_pkg::OSD_LK2;
         end else begin
            s_d.ul = osd_pkg::OSD_LK0;
         end
      end else if (wr) begin
         s_d.ul = osd_pkg::OSD_LK0;
      end
      if (wr && paddr == osd_pkg::OFS_OSC_CTRL && s_q.ul == osd_pkg::OSD_LK2) begin
         s_d.r.pin_lock = pwdata[osd_pkg::B_PIN_CONFIG_LOCK];
         if (!locked_cfg) begin
            s_d.r.clk_lock = pwdata[osd_pkg::B_CLOCK_CONFIG_LOCK];
            if (field(pwdata, osd_pkg::B_NEXT_SOURCE_SEL, 3) != {29'h0, osd_pkg::SRC_RESERVED}) begin
               s_d.r.next_src = pwdata[osd_pkg::B_NEXT_SOURCE_SEL +: 3];
            end
            if (pwdata[osd_pkg::B_SOURCE_SWITCH_REQUEST] && s_q.sw == osd_pkg::OSD_IDLE) begin
               s_d.r.switch_req = 1'b1;
               s_d.sw = osd_pkg::OSD_WAIT;
            end
         end
         if (pwdata[osd_pkg::B_CF]) begin
            s_d.r.fail_flag = 1'b1;
            s_d.trap = 1'b1;
         end else begin
            s_d.r.fail_flag = 1'b0;
         end
      end
      if (wr && paddr == osd_pkg::OFS_CLK_DIV && !locked_cfg) begin
         s_d.r.recover_on_irq = pwdata[osd_pkg::B_ROI];
         s_d.r.fast_rc_postscaler = pwdata[osd_pkg::B_FAST_RC_POSTSCALER +: 3];
         if (pwdata[osd_pkg::B_POST +: 2] != osd_pkg::POST_RSVD) begin
            s_d.r.post = pwdata[osd_pkg::B_POST +: 2];
         end
         s_d.r.pre = pwdata[osd_pkg::B_PRE +: 5];
         if (!s_q.r.reduced_ratio_enable) begin
            s_d.r.doze = pwdata[osd_pkg::B_DOZE +: 3];
         end
         if (!pwdata[osd_pkg::B_REDUCED_RATIO_ENABLE] || s_q.r.doze != osd_pkg::DOZE_NONE) begin
            s_d.r.reduced_ratio_enable = pwdata[osd_pkg::B_REDUCED_RATIO_ENABLE];
         end
      end
      if (wr && paddr == osd_pkg::OFS_PLL_FBD && !locked_cfg) begin
         s_d.r.fbd = pwdata[8:0];
      end
      if (irq_any && s_q.r.recover_on_irq) begin
         s_d.r.reduced_ratio_enable = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle
      if (fail_evt) begin
         s_d.r.fail_flag = 1'b1;
         s_d.trap = ~s_q.r.fail_flag | s_d.trap;
      end
      case (s_q.sw)
         osd_pkg::OSD_IDLE: begin
         end
         osd_pkg::OSD_WAIT: begin
            if (s_q.sy_ready[2]) begin
               s_d.sw = osd_pkg::OSD_SWAP;
            end
         end
         osd_pkg::OSD_SWAP: begin
            s_d.r.cur_src = s_q.r.next_src;
            s_d.r.switch_req = 1'b0;
            s_d.sw = osd_pkg::OSD_IDLE;
         end
         default: s_d.sw = osd_pkg::OSD_IDLE;
      endcase
      if (rst) begin
         s_d = '0;
         s_d.r.doze = osd_pkg::DOZE_RST;
         s_d.r.fast_rc_postscaler = osd_pkg::FAST_RC_POSTSCALER_RST;
         s_d.r.post = osd_pkg::POST_RST;
         s_d.r.pre = osd_pkg::PRE_RST;
         s_d.r.fbd = osd_pkg::FBD_RST;
      end
      if (por_load) begin
         s_d.r.next_src = cfg_next_source_sel;
         s_d.r.cur_src = cfg_next_source_sel;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign prdata = s_q.rdata;
   assign io_lock_active = s_q.r.pin_lock;
   assign osc_fail_trap = s_q.trap;
   always_comb begin
      clk_cfg.source  = s_q.r.cur_src;
      clk_cfg.frc_div = s_q.r.fast_rc_postscaler;
      clk_cfg.post    = s_q.r.post;
      clk_cfg.pre     = s_q.r.pre;
      clk_cfg.fbd     = s_q.r.fbd;
      clk_cfg.doze_ratio = s_q.r.reduced_ratio_enable ? s_q.r.doze : osd_pkg::DOZE_NONE;
   end

   reduced_ratio_enable_forced_a: assert property (@(posedge clk) disable iff (rst)
      (irq_any && s_q.r.recover_on_irq && !por_load) |=> !s_q.r.reduced_ratio_enable) else $error("interrupt did not clear doze");
   doze_hold_a: assert property (@(posedge clk) disable iff (rst)
      (s_q.r.reduced_ratio_enable && !por_load) |=> $stable(s_q.r.doze)) else $error("doze changed while enabled");
   reduced_ratio_enable_zero_a: assert property (@(posedge clk) disable iff (rst)
      (s_q.r.doze == osd_pkg::DOZE_NONE && !s_q.r.reduced_ratio_enable) |=> !s_q.r.reduced_ratio_enable) else $error("doze enabled at zero");
   ratio_one_a: assert property (@(posedge clk) disable iff (rst)
      !s_q.r.reduced_ratio_enable |-> clk_cfg.doze_ratio == osd_pkg::DOZE_NONE) else $error("ratio not 1:1");
   lock_block_a: assert property (@(posedge clk) disable iff (rst || por_load)
      (locked_cfg && !por_load) |=> $stable(s_q.r.fbd) && $stable(s_q.r.pre)) else $error("locked config changed");
   swap_done_a: assert property (@(posedge clk) disable iff (rst || por_load)
      (s_q.sw == osd_pkg::OSD_SWAP) |=> !s_q.r.switch_req && s_q.r.cur_src == $past(s_q.r.next_src)) else $error("switch not completed");
   fail_set_a: assert property (@(posedge clk) disable iff (rst)
      fail_evt |=> s_q.r.fail_flag) else $error("fail flag not set");
   post_rsvd_a: assert property (@(posedge clk) disable iff (rst)
      s_q.r.post != osd_pkg::POST_RSVD) else $error("reserved postscaler code");
   unlock_need_a: assert property (@(posedge clk) disable iff (rst || por_load)
      (wr && paddr == osd_pkg::OFS_OSC_CTRL && s_q.ul != osd_pkg::OSD_LK2 && !fail_evt)
      |=> $stable(s_q.r.pin_lock)) else $error("write without unlock");
endmodule

/* verification/osd_ctrl_tb.sv */
module osd_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 por_load = 1'b1;
   logic                 clock_switch_monitor_cfg0 = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0000_0000;
   logic [31:0]          prdata;
   logic [31:0]          rdat = 32'h0000_0000;
   logic                 pready;
   logic                 irq_any = 1'b0;
   logic                 src_rdy = 1'b0;
   logic                 pll_lk = 1'b0;
   logic                 fail_det = 1'b0;
   osd_pkg::osd_clkcfg_t clk_cfg;
   logic                 io_lock;
   logic                 trap;
   int                   traps = 0;
   int                   num_errors = 0;
   int                   compares = 0;
   osd_ctrl dut (.clk(clk), .rst(rst), .por_load(por_load), .cfg_next_source_sel(3'h2), .cfg_clock_switch_monitor_cfg0(clock_switch_monitor_cfg0),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(), .irq_any(irq_any), .src_ready_async(src_rdy), .pll_lock_async(pll_lk),
      .fail_detect_async(fail_det), .clk_cfg(clk_cfg), .io_lock_active(io_lock), .osc_fail_trap(trap));
   always #10 clk = ~clk;
   always @(posedge clk) if (trap === 1'b1) traps <= traps + 1;
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // Master holds everything until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Read data is taken at the edge where pready is seen high
   task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, e, rdat);
   endtask
   task automatic osc_wr(input logic [31:0] d);
      xfer(1'b1, 12'h00C, 32'h0000_0057);
      xfer(1'b1, 12'h00C, 32'h0000_00AA);
      xfer(1'b1, 12'h000, d);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      por_load <= 1'b0;
      @(posedge clk);
      rdchk("osc_reset", 12'h000, 32'h0000_2200);
      rdchk("div_reset", 12'h004, 32'h0000_3040);
      rdchk("fbd_reset", 12'h008, 32'h0000_0030);
      $display("test reset done");
      xfer(1'b1, 12'h004, 32'h0000_37DF);
      rdchk("div_fields", 12'h004, 32'h0000_37DF);
      chk("cfg_pre", 32'h0000_001F, 32'(clk_cfg.pre));
      chk("cfg_post", 32'h0000_0003, 32'(clk_cfg.post));
      chk("ratio_off", 32'h0000_0000, 32'(clk_cfg.doze_ratio));
      xfer(1'b1, 12'h004, 32'h0000_3800);
      chk("ratio_on", 32'h0000_0003, 32'(clk_cfg.doze_ratio));
      xfer(1'b1, 12'h004, 32'h0000_5800);
      rdchk("doze_frozen", 12'h004, 32'h0000_3800);
      // First write only clears enable; field is still frozen during it
      xfer(1'b1, 12'h004, 32'h0000_0000);
      xfer(1'b1, 12'h004, 32'h0000_0000);
      xfer(1'b1, 12'h004, 32'h0000_0800);
      rdchk("reduced_ratio_enable_blocked", 12'h004, 32'h0000_0000);
      xfer(1'b1, 12'h004, 32'h0000_3000);
      xfer(1'b1, 12'h004, 32'h0000_B800);
      irq_any <= 1'b1;
      @(posedge clk);
      irq_any <= 1'b0;
      @(posedge clk);
      rdchk("roi_recover", 12'h004, 32'h0000_B000);
      $display("test divisor done");
      xfer(1'b1, 12'h000, 32'h0000_0040);
      rdchk("osc_no_unlock", 12'h000, 32'h0000_2200);
      // Primary to plain fast RC: never straight between PLL sources
      osc_wr(32'h0000_0001);
      repeat (6) @(posedge clk);
      rdchk("switch_pending", 12'h000, 32'h0000_2001);
      src_rdy <= 1'b1;
      repeat (8) @(posedge clk);
      rdchk("switch_done", 12'h000, 32'h0000_0000);
      src_rdy <= 1'b0;
      osc_wr(32'h0000_0440);
      rdchk("next_source_sel_reserved", 12'h000, 32'h0000_0040);
      chk("io_lock", 32'h0000_0001, 32'(io_lock));
      $display("test switch done");
      osc_wr(32'h0000_0048);
      repeat (2) @(posedge clk);
      chk("trap_count", 32'h0000_0001, 32'(traps));
      osc_wr(32'h0000_0040);
      rdchk("cf_clear", 12'h000, 32'h0000_0040);
      fail_det <= 1'b1;
      repeat (5) @(posedge clk);
      fail_det <= 1'b0;
      pll_lk <= 1'b1;
      repeat (5) @(posedge clk);
      rdchk("cf_lock_set", 12'h000, 32'h0000_0068);
      $display("test status done");
      xfer(1'b1, 12'h008, 32'h0000_01FF);
      clock_switch_monitor_cfg0 <= 1'b1;
      osc_wr(32'h0000_00C0);
      rdchk("clk_lock_on", 12'h000, 32'h0000_00E0);
      osc_wr(32'h0000_02C1);
      rdchk("osc_locked", 12'h000, 32'h0000_00E0);
      xfer(1'b1, 12'h008, 32'h0000_0010);
      rdchk("fbd_locked", 12'h008, 32'h0000_01FF);
      clock_switch_monitor_cfg0 <= 1'b0;
      xfer(1'b1, 12'h008, 32'h0000_0010);
      rdchk("fbd_unlocked", 12'h008, 32'h0000_0010);
      $display("test lock done");
      give_verdict();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
endmodule
